//--- logic/aomr_pkg.sv
// Constants, field layouts and carrier types of the output mode register bank.
//
// Operation
// - Bits 7-5 select output driver current.
// - Bit 3 disables the digital outputs; the code only holds outValid low, outData still updates.
// - Bit 2 turns the test pattern on.
// - Bits 1-0 select one, two or four lanes.
// - Address 03h holds pattern bits 15-8.
// - Address 04h holds pattern bits 7-0.
// - Output mode register: address 02h, eight bits.
// - Word: read flag, seven address, eight data.
// - Sample first 16 clock rises, ignore later.
// - Read keeps register, returns it open-drain.
// - Software reset clears all registers to 00h.
`default_nettype none
package aomr_pkg;
  localparam int WordBits = 16;
  localparam int DataBits = 8;
  localparam logic [4:0] WordLast = 5'h0f;
  localparam logic [4:0] AddrLast = 5'h07;
  localparam logic [4:0] WordDone = 5'h10;
  localparam logic [6:0] AddrReset = 7'h00;
  localparam logic [6:0] AddrOutCfg = 7'h02;
  localparam logic [6:0] AddrPatHi = 7'h03;
  localparam logic [6:0] AddrPatLo = 7'h04;
  localparam int SoftResetBit = 7;
  localparam logic [7:0] RegReset = 8'h00;
  localparam logic [1:0] LaneTwo = 2'h0;
  localparam logic [1:0] LaneFour = 2'h1;
  localparam logic [1:0] LaneOne = 2'h2;
  // Driver current per select code in microamps; code 3 is unassigned and reads as zero.
  localparam logic [13:0] CurrentUa [8] = '{14'h0dac, 14'h0fa0, 14'h1194, 14'h0000,
                                            14'h0bb8, 14'h09c4, 14'h0834, 14'h06d6};

  typedef struct packed {
    logic [2:0] driveCurrentSelect;
    logic internalTermEnable;
    logic digitalOutputDisable;
    logic patternOutputEnable;
    logic [1:0] laneCountSelect;
  } aomr_cfg_s;

  typedef struct packed {
    logic csN;
    logic sck;
    logic sdi;
  } aomr_spi_s;

  typedef enum logic [1:0] {SPI_IDLE, SPI_SHIFT, SPI_HOLD} aomr_spi_e;
endpackage
`default_nettype wire

//--- logic/aomr_output_regs.sv
// Serial configuration slave with output mode and test pattern registers.
`default_nettype none
module aomr_output_regs #(
  parameter int PatternBits = 16
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire aomr_pkg::aomr_spi_s spiIn, // Raw serial port pins.
  output logic sdoOut, // Open-drain data, always low.
  output logic sdoOeN, // Low while pulling the data pin low.
  input wire logic [PatternBits-1:0] convData, // Conversion result.
  input wire logic convValid, // Conversion result strobe.
  output aomr_pkg::aomr_cfg_s cfg, // Output mode fields.
  output logic [13:0] driveCurrentUa, // Effective driver current in microamps.
  output logic [PatternBits-1:0] outData, // Data towards the serializer.
  output logic outValid // Data strobe, low while outputs are disabled.
);
  import aomr_pkg::*;

  // Elaboration stops here when the pattern is not exactly two register bytes.
  if (PatternBits != 2 * DataBits) begin : g_width_check
    $error("PatternBits must equal two register bytes");
  end

  aomr_spi_s pinSync1_q, pinSync2_q, pinPrev_q;
  aomr_spi_e state_q, state_d;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [14:0] shift_q, shift_d;
  logic [7:0] rdShift_q, rdShift_d;
  logic sdoOeN_q, sdoOeN_d;
  aomr_cfg_s cfg_q, cfg_d;
  logic [7:0] patHi_q, patHi_d, patLo_q, patLo_d;
  logic [13:0] curUa_q, curUa_d;
  logic [PatternBits-1:0] outData_q, outData_d;
  logic outValid_q, outValid_d;
  logic sckRise, csFall, csHigh;
  logic wrStb, rdStb;
  logic [15:0] word;
  logic [6:0] wrAddr, rdAddr;
  logic [7:0] wrData, rdVal;

  // Pins pass two flops; only the second stage is compared for edges.
  always_ff @(posedge clk) begin
    if (rst) begin
      pinSync1_q <= '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
      pinSync2_q <= '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
      pinPrev_q <= '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
    end else begin
      pinSync1_q <= spiIn;
      pinSync2_q <= pinSync1_q;
      pinPrev_q <= pinSync2_q;
    end
  end

  assign sckRise = pinSync2_q.sck && !pinPrev_q.sck && !pinSync2_q.csN;
  assign csFall = !pinSync2_q.csN && pinPrev_q.csN;
  assign csHigh = pinSync2_q.csN;
  assign word = {shift_q, pinSync2_q.sdi};
  assign wrAddr = word[14:8];
  assign wrData = word[7:0];
  assign rdAddr = word[6:0];
  assign wrStb = (state_q == SPI_SHIFT) && sckRise && (bitCnt_q == WordLast) && !word[15];
  assign rdStb = (state_q == SPI_SHIFT) && sckRise && (bitCnt_q == AddrLast) && word[7];

  always_comb begin
    if (rdAddr == AddrOutCfg) begin
      rdVal = cfg_q;
    end else if (rdAddr == AddrPatHi) begin
      rdVal = patHi_q;
    end else if (rdAddr == AddrPatLo) begin
      rdVal = patLo_q;
    end else begin
      rdVal = RegReset;
    end
  end

  // Frame sequencing and read-back shifter.
  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    rdShift_d = rdShift_q;
    sdoOeN_d = sdoOeN_q;
    if (csHigh) begin
      state_d = SPI_IDLE;
      sdoOeN_d = 1'b1;
    end else if (csFall) begin
      state_d = SPI_SHIFT;
      bitCnt_d = 5'h00;
      // A read cut short must not leak its remaining bits into the next frame.
      rdShift_d = 8'hff;
      sdoOeN_d = 1'b1;
    end else if (state_q == SPI_SHIFT && sckRise) begin
      shift_d = word[14:0];
      bitCnt_d = bitCnt_q + 5'h01;
      if (bitCnt_q == WordLast) begin
        state_d = SPI_HOLD;
        sdoOeN_d = 1'b1;
      end else if (rdStb) begin
        rdShift_d = {rdVal[6:0], 1'b1};
        sdoOeN_d = rdVal[7];
      end else if (bitCnt_q > AddrLast) begin
        rdShift_d = {rdShift_q[6:0], 1'b1};
        sdoOeN_d = rdShift_q[7];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SPI_IDLE;
      bitCnt_q <= 5'h00;
      shift_q <= 15'h0000;
      rdShift_q <= 8'hff;
      sdoOeN_q <= 1'b1;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      rdShift_q <= rdShift_d;
      sdoOeN_q <= sdoOeN_d;
    end
  end

  // Register bank, read commands never reach it.
  always_comb begin
    cfg_d = cfg_q;
    patHi_d = patHi_q;
    patLo_d = patLo_q;
    if (wrStb) begin
      if (wrAddr == AddrReset) begin
        if (wrData[SoftResetBit]) begin
          cfg_d = RegReset;
          patHi_d = RegReset;
          patLo_d = RegReset;
        end
      end else if (wrAddr == AddrOutCfg) begin
        cfg_d = wrData;
      end else if (wrAddr == AddrPatHi) begin
        patHi_d = wrData;
      end else if (wrAddr == AddrPatLo) begin
        patLo_d = wrData;
      end
    end
  end

  // Output path: current code, pattern substitution and output disable.
  always_comb begin
    curUa_d = CurrentUa[cfg_d.driveCurrentSelect];
    if (cfg_d.internalTermEnable) begin
      curUa_d = {CurrentUa[cfg_d.driveCurrentSelect][12:0], 1'b0};
    end
    outData_d = outData_q;
    if (convValid) begin
      outData_d = cfg_q.patternOutputEnable ? {patHi_q, patLo_q} : convData;
    end
    outValid_d = convValid && !cfg_q.digitalOutputDisable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= RegReset;
      patHi_q <= RegReset;
      patLo_q <= RegReset;
      curUa_q <= CurrentUa[0];
      outData_q <= '0;
      outValid_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      patHi_q <= patHi_d;
      patLo_q <= patLo_d;
      curUa_q <= curUa_d;
      outData_q <= outData_d;
      outValid_q <= outValid_d;
    end
  end

  assign sdoOut = 1'b0;
  assign sdoOeN = sdoOeN_q;
  assign cfg = cfg_q;
  assign driveCurrentUa = curUa_q;
  assign outData = outData_q;
  assign outValid = outValid_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write(logic [6:0] a);
    wrStb && wrAddr == a;
  endsequence

  a_cfg_write: assert property (s_write(AddrOutCfg) |=> cfg_q == $past(wrData))
    else $error("output mode register not written");
  a_pat_write: assert property (s_write(AddrPatHi) |=>
    patHi_q == $past(wrData) ##1 $stable(patLo_q))
    else $error("pattern high byte not written");
  a_pat_low_write: assert property (s_write(AddrPatLo) |=> patLo_q == $past(wrData))
    else $error("pattern low byte not written");
  a_soft_reset: assert property (s_write(AddrReset) ##0 wrData[7] |=>
    cfg_q == 8'h00 && {patHi_q, patLo_q} == 16'h0000)
    else $error("software reset did not clear registers");
  a_read_keeps: assert property (rdStb |=>
    $stable(cfg_q) && $stable(patHi_q) && $stable(patLo_q))
    else $error("read command changed a register");
  a_read_first_bit: assert property (rdStb |=> sdoOeN_q == $past(rdVal[7]))
    else $error("read-back bit 7 wrong");
  a_current_map: assert property (curUa_q == (cfg_q.internalTermEnable ?
    {CurrentUa[cfg_q.driveCurrentSelect][12:0], 1'b0} :
    CurrentUa[cfg_q.driveCurrentSelect]))
    else $error("driver current does not match select code");
  a_pattern_sub: assert property (convValid && cfg_q.patternOutputEnable |=>
    outData_q == $past({patHi_q, patLo_q}))
    else $error("test pattern not substituted");
  a_out_disable: assert property (convValid && cfg_q.digitalOutputDisable |=> !outValid_q)
    else $error("disabled output still strobed");
  a_bit_limit: assert property (bitCnt_q <= WordDone)
    else $error("bit counter beyond word length");
  a_extra_ignored: assert property (state_q == SPI_HOLD && sckRise && !csFall |=>
    $stable(shift_q) && $stable(cfg_q))
    else $error("clock edge after sixteenth bit was used");
  a_frame_end: assert property (csHigh |=> state_q == SPI_IDLE && sdoOeN_q)
    else $error("frame not ended by chip select");
endmodule
`default_nettype wire

//--- dv/aomr_host_model.sv
// Host controller model that frames 16-bit words on the serial configuration port.
`default_nettype none
module aomr_host_model (
  output var aomr_pkg::aomr_spi_s spi, // Serial port pins towards the block.
  input wire logic clk, // System clock.
  input wire logic sdoLine // Resolved open-drain data line.
);
  timeunit 1ns;
  timeprecision 1ns;
  import aomr_pkg::*;
  initial spi = '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
  // Sends n clock rises; counts other than 16 model an abort or surplus edges.
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    spi.csN <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      spi.sdi <= (i < WordBits) ? w[15-i] : ~spi.sdi;
      repeat (4) @(posedge clk);
      if (i > 7 && i < WordBits) rd = {rd[6:0], sdoLine};
      spi.sck <= 1'b1;
      repeat (4) @(posedge clk);
      spi.sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spi.csN <= 1'b1;
    spi.sdi <= ~spi.sdi;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- dv/aomr_output_regs_test.sv
// Self-checking bench for the output mode and test pattern registers.
`default_nettype none
module aomr_output_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import aomr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  aomr_spi_s spi;
  logic sdoOut, sdoOeN, outValid;
  logic convValid = 1'b0;
  logic [15:0] convData = 16'h0000;
  logic [15:0] outData;
  logic [13:0] driveCurrentUa;
  aomr_cfg_s cfg;
  logic [7:0] rd;
  logic [13:0] ua [8] = '{14'h0dac, 14'h0fa0, 14'h1194, 14'h0000,
                          14'h0bb8, 14'h09c4, 14'h0834, 14'h06d6};
  int fails = 0;
  int compares = 0;
  // The pull-up gives a high level whenever the block releases the line.
  wire logic sdoLine = sdoOeN ? 1'b1 : sdoOut;
  always #5 clk = ~clk;
  aomr_output_regs dut (.clk(clk), .rst(rst), .spiIn(spi), .sdoOut(sdoOut),
    .sdoOeN(sdoOeN), .convData(convData), .convValid(convValid), .cfg(cfg),
    .driveCurrentUa(driveCurrentUa), .outData(outData), .outValid(outValid));
  aomr_host_model host (.spi(spi), .clk(clk), .sdoLine(sdoLine));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b0, a, d}, WordBits, rd);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer({1'b1, a, 8'h5a}, WordBits, rd);
    chk("readback", {8'h00, exp}, {8'h00, rd});
  endtask
  task automatic conv(input logic [15:0] d, input logic [15:0] expData, input logic expV);
    convData <= d;
    convValid <= 1'b1;
    @(posedge clk);
    convValid <= 1'b0;
    #1;
    chk("outData", expData, outData);
    chk("outValid", {15'h0000, expV}, {15'h0000, outValid});
    @(posedge clk);
  endtask
  task automatic results;
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cfg", 16'h0000, {8'h00, cfg});
    chk("current", 16'h0dac, {2'h0, driveCurrentUa});
    for (int c = 0; c < 8; c++) begin
      for (int t = 0; t < 2; t++) begin
        if (c != 3) begin
          wr(AddrOutCfg, {c[2:0], t[0], 2'h0, 2'(c % 3)});
          chk("cfg", {8'h00, c[2:0], t[0], 2'h0, 2'(c % 3)}, {8'h00, cfg});
          chk("current", {2'h0, ua[c] << t}, {2'h0, driveCurrentUa});
        end
      end
    end
    wr(AddrPatHi, 8'ha5);
    wr(AddrPatLo, 8'h3c);
    rdchk(AddrPatHi, 8'ha5);
    rdchk(AddrPatLo, 8'h3c);
    wr(AddrOutCfg, 8'h04);
    conv(16'h1234, 16'ha53c, 1'b1);
    wr(AddrOutCfg, 8'h08);
    conv(16'h1234, 16'h1234, 1'b0);
    rdchk(AddrOutCfg, 8'h08);
    host.xfer({1'b0, AddrPatHi, 8'h77}, 8, rd);
    rdchk(AddrPatHi, 8'ha5);
    host.xfer({1'b0, AddrPatLo, 8'h81}, 20, rd);
    rdchk(AddrPatLo, 8'h81);
    wr(AddrReset, 8'h80);
    chk("cfg", 16'h0000, {8'h00, cfg});
    rdchk(AddrPatHi, 8'h00);
    rdchk(AddrPatLo, 8'h00);
    results();
  end
endmodule
`default_nettype wire
